/* src/scsm_top.sv */
// Behaviour
// - cpu tick divides prescaler input by 1, 2, 4, 12; 32k crystal bypasses divider
// - every reset sets the crystal speed-up bit to one
// - software may set or clear the speed-up bit at any time
// - speed-up bit acts only for options 1010 or 1101
// - fast-rc-on bit switches the fast RC clock off or on
// - fast-clock-select chooses slow source or fast RC as prescaler input
// - fast-rc-on and fast-select act only for options 0011, 0110, 1010
// - fast selectable clock is the internal 12 MHz RC under those options
// - clearing fast-rc-on is ignored while fast-rc-on and fast-select are both set
// - stopped oscillator makes monitor switch to watchdog RC and set fail flag
// - fail flag raises interrupt when global and monitor enables are set
// - returning oscillator switches back and clears fail flag by hardware
// - option codes pick internal RC, 32k crystal, fast crystal or 128k RC
// - fail flag is read only, only hardware changes it
// - monitor stays inactive when an internal RC option feeds the prescaler
`timescale 1ns/1ps
module scsm_top #(
	parameter int MON_TIMEOUT = scsm_pkg::MON_TIMEOUT_CYC
) (
	input  wire logic                        clk,
	input  wire logic                        sys_rst,
	input  wire logic [scsm_pkg::ADDR_W-1:0] paddr,
	input  wire logic                        psel,
	input  wire logic                        penable,
	input  wire logic                        pwrite,
	input  wire logic [31:0]                 pwdata,
	input  wire logic [3:0]                  pstrb,
	output logic      [31:0]                 prdata,
	output logic                             pready,
	output logic                             pslverr,
	input  wire logic [3:0]                  osc_type_option,
	input  wire logic                        osc_tick,
	input  wire logic                        fast_rc_tick,
	input  wire logic                        watchdog_rc_tick,
	input  wire logic                        global_irq_enable,
	output logic                             cpu_tick,
	output logic                             fast_rc_enable,
	output logic                             xtal32k_speedup_en,
	output logic                             osc_on_watchdog,
	output logic                             irq
);
	import scsm_pkg::*;

	typedef struct packed {
		scsm_ctrl_t             ctrl;
		logic [3:0]             opt;
		logic                   opt_ok;
		scsm_mon_t              mon;
		logic                   fail;
		logic [MON_CNT_W-1:0]   idle_cnt;
		logic [2:0]             resume_cnt;
		logic                   use_fast;
		logic                   ev_status;
		logic                   ev_mask;
		logic                   irq;
		logic                   fast_en;
		logic                   speedup_en;
		logic                   pready;
		logic                   pslverr;
		logic [31:0]            prdata;
	} scsm_state_t;

	localparam logic [MON_CNT_W-1:0] TIMEOUT_LAST = MON_CNT_W'(MON_TIMEOUT - 1);

	scsm_state_t s_q;
	scsm_state_t s_d;
	logic        presc_tick;
	logic [1:0]  eff_div;
	logic        osc_clk_tick;
	logic        want_fast;
	logic        setup_acc;
	logic        done_acc;
	logic        wr_ctrl;
	logic        wr_status;
	logic        wr_mask;
	logic        fail_event;

	function automatic logic addr_mapped(input logic [ADDR_W-1:0] a);
		addr_mapped = (a == ADDR_CLK_CTRL) || (a == ADDR_IRQ_STATUS) || (a == ADDR_IRQ_MASK);
	endfunction

	// prescaler source: watchdog RC replaces the oscillator while it has failed
	assign osc_clk_tick = (s_q.mon == MON_FAIL) ? watchdog_rc_tick : osc_tick;
	assign presc_tick   = s_q.use_fast ? fast_rc_tick : osc_clk_tick;
	// the 32k crystal drives the cpu directly
	assign eff_div      = (opt_xtal32k(s_q.opt) && !s_q.use_fast) ? DIV_1 : s_q.ctrl.div_sel;
	assign want_fast    = opt_fast_sel(s_q.opt) && s_q.ctrl.fast_rc_on && s_q.ctrl.fs;

	assign setup_acc = psel && penable && !s_q.pready;
	assign done_acc  = psel && penable && s_q.pready && !s_q.pslverr;
	assign wr_ctrl   = done_acc && pwrite && pstrb[0] && (paddr == ADDR_CLK_CTRL);
	assign wr_status = done_acc && pwrite && pstrb[0] && (paddr == ADDR_IRQ_STATUS);
	assign wr_mask   = done_acc && pwrite && pstrb[0] && (paddr == ADDR_IRQ_MASK);

	always_comb begin
		s_d        = s_q;
		fail_event = 1'b0;

		// code option is caught once, just after reset release
		if (!s_q.opt_ok) begin
			s_d.opt    = osc_type_option;
			s_d.opt_ok = 1'b1;
		end

		// control register write
		if (wr_ctrl) begin
			s_d.ctrl.speedup = pwdata[BIT_SPEEDUP];
			s_d.ctrl.div_sel = pwdata[BIT_DIV_HI:BIT_DIV_LO];
			s_d.ctrl.fs      = pwdata[BIT_FS];
			s_d.ctrl.fast_rc_on    = pwdata[BIT_FAST_RC_ON];
			if (s_q.ctrl.fast_rc_on && s_q.ctrl.fs) begin
				s_d.ctrl.fast_rc_on = 1'b1;
			end
		end
		if (wr_mask) begin
			s_d.ev_mask = pwdata[BIT_EV_FAIL];
		end

		// source switch only at a cpu period boundary, or when nothing runs
		if (cpu_tick || !s_q.use_fast && !want_fast) begin
			s_d.use_fast = want_fast;
		end else if (s_q.use_fast && !opt_fast_sel(s_q.opt)) begin
			s_d.use_fast = 1'b0;
		end

		// fast RC keeps running while it still feeds the prescaler
		s_d.fast_en    = opt_fast_sel(s_q.opt) && (s_q.ctrl.fast_rc_on || s_q.use_fast);
		s_d.speedup_en = opt_xtal32k(s_q.opt) && s_q.ctrl.speedup;

		// clock monitor
		if (!opt_monitored(s_q.opt)) begin
			s_d.mon        = MON_OK;
			s_d.fail       = 1'b0;
			s_d.idle_cnt   = '0;
			s_d.resume_cnt = 3'h0;
		end else begin
			if (osc_tick) begin
				s_d.idle_cnt = '0;
			end else if (s_q.idle_cnt != TIMEOUT_LAST) begin
				s_d.idle_cnt = MON_CNT_W'(s_q.idle_cnt + 1'b1);
			end
			unique case (s_q.mon)
				MON_OK: begin
					if (!osc_tick && s_q.idle_cnt == TIMEOUT_LAST) begin
						s_d.mon        = MON_FAIL;
						s_d.fail       = 1'b1;
						s_d.resume_cnt = 3'h0;
						fail_event     = 1'b1;
					end
				end
				MON_FAIL: begin
					if (osc_tick) begin
						if (s_q.resume_cnt == RESUME_TICKS - 3'h1) begin
							s_d.mon  = MON_OK;
							s_d.fail = 1'b0;
						end else begin
							s_d.resume_cnt = 3'(s_q.resume_cnt + 3'h1);
						end
					end else if (s_q.idle_cnt == TIMEOUT_LAST) begin
						s_d.resume_cnt = 3'h0;
					end
				end
			endcase
		end

		// sticky event, write one to clear; a new event wins over the clear
		if (wr_status && pwdata[BIT_EV_FAIL]) begin
			s_d.ev_status = 1'b0;
		end
		if (fail_event) begin
			s_d.ev_status = 1'b1;
		end
		s_d.irq = s_q.ev_status && s_q.ev_mask && global_irq_enable;

		// apb answer: one wait state, data and error ready with pready
		s_d.pready  = setup_acc;
		s_d.pslverr = setup_acc && !addr_mapped(paddr);
		s_d.prdata  = 32'h0;
		if (setup_acc && !pwrite) begin
			unique case (paddr)
				ADDR_CLK_CTRL: begin
					s_d.prdata[BIT_SPEEDUP]         = s_q.ctrl.speedup;
					s_d.prdata[BIT_DIV_HI:BIT_DIV_LO] = s_q.ctrl.div_sel;
					s_d.prdata[BIT_FAIL]            = s_q.fail;
					s_d.prdata[BIT_FAST_RC_ON]            = s_q.ctrl.fast_rc_on;
					s_d.prdata[BIT_FS]              = s_q.ctrl.fs;
				end
				ADDR_IRQ_STATUS: s_d.prdata[BIT_EV_FAIL] = s_q.ev_status;
				ADDR_IRQ_MASK:   s_d.prdata[BIT_EV_FAIL] = s_q.ev_mask;
				default:         s_d.prdata = 32'h0;
			endcase
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			s_q <= '{
				ctrl:       '{speedup: RST_SPEEDUP, div_sel: RST_DIV, fast_rc_on: RST_FAST_RC_ON, fs: RST_FS},
				opt:        OPT_IRC_A,
				opt_ok:     1'b0,
				mon:        MON_OK,
				fail:       1'b0,
				idle_cnt:   '0,
				resume_cnt: 3'h0,
				use_fast:   1'b0,
				ev_status:  1'b0,
				ev_mask:    RST_MASK,
				irq:        1'b0,
				fast_en:    1'b0,
				speedup_en: 1'b0,
				pready:     1'b0,
				pslverr:    1'b0,
				prdata:     32'h0
			};
		end else begin
			s_q <= s_d;
		end
	end

	scsm_prescaler u_prescaler (
		.clk      (clk),
		.sys_rst  (sys_rst),
		.src_tick (presc_tick),
		.div_sel  (eff_div),
		.cpu_tick (cpu_tick)
	);

	assign prdata             = s_q.prdata;
	assign pready             = s_q.pready;
	assign pslverr            = s_q.pslverr;
	assign fast_rc_enable     = s_q.fast_en;
	assign xtal32k_speedup_en = s_q.speedup_en;
	assign osc_on_watchdog    = (s_q.mon == MON_FAIL);
	assign irq                = s_q.irq;

	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	sequence seq_both_on;
		s_q.ctrl.fast_rc_on && s_q.ctrl.fs;
	endsequence

	sequence seq_clear_fast_rc_on;
		wr_ctrl && !pwdata[BIT_FAST_RC_ON];
	endsequence

	sequence seq_osc_lost;
		opt_monitored(s_q.opt) && s_q.mon == MON_OK
		&& !osc_tick && s_q.idle_cnt == TIMEOUT_LAST;
	endsequence

	sequence seq_fallback;
		osc_on_watchdog && s_q.fail && s_q.ev_status;
	endsequence

	sequence seq_apb_wait;
		psel && penable && !pready;
	endsequence

	chk_speedup_reset: assert property ($past(sys_rst) |-> s_q.ctrl.speedup)
		else $error("speed-up bit not set after reset");

	chk_fast_rc_on_hold: assert property (seq_both_on and seq_clear_fast_rc_on |=> s_q.ctrl.fast_rc_on)
		else $error("fast rc on cleared while selected");

	chk_speedup_gate: assert property (
		!opt_xtal32k(s_q.opt) |=> !xtal32k_speedup_en)
		else $error("speed-up active under wrong option");

	chk_fast_gate: assert property (!opt_fast_sel($past(s_q.opt)) |-> !fast_rc_enable)
		else $error("fast rc enabled under wrong option");

	chk_fail_switch: assert property (
		$rose(s_q.fail) |-> osc_on_watchdog ##[1:2] s_q.ev_status)
		else $error("failure did not switch to watchdog clock");

	chk_irq_raise: assert property (
		s_q.ev_status && s_q.ev_mask && global_irq_enable |=> irq)
		else $error("interrupt not raised");

	chk_fail_resume: assert property (
		s_q.mon == MON_FAIL && osc_tick && s_q.resume_cnt == RESUME_TICKS - 3'h1
		&& opt_monitored(s_q.opt) |=> !s_q.fail && !osc_on_watchdog)
		else $error("fail flag not cleared on resume");

	chk_fail_ro: assert property (
		wr_ctrl && !fail_event && s_q.mon == MON_OK && s_q.fail == 1'b0
		&& !(s_q.idle_cnt == TIMEOUT_LAST) |=> !s_q.fail)
		else $error("software changed fail flag");

	chk_mon_idle: assert property (!opt_monitored(s_q.opt) |=> !s_q.fail)
		else $error("monitor active under internal rc option");

	chk_apb_answer: assert property (seq_apb_wait |=> pready)
		else $error("register access not answered after one wait state");

	chk_apb_pulse: assert property (pready |=> !pready)
		else $error("ready held longer than one cycle");

	chk_slverr_pair: assert property (pslverr |-> pready)
		else $error("error response without ready");

	chk_speedup_write: assert property (
		wr_ctrl |=> s_q.ctrl.speedup == $past(pwdata[BIT_SPEEDUP]))
		else $error("speed-up bit did not take the written value");

	chk_speedup_on: assert property (
		opt_xtal32k(s_q.opt) && s_q.ctrl.speedup |=> xtal32k_speedup_en)
		else $error("speed-up not active for the 32k crystal");

	chk_fast_rc_on_write: assert property (
		wr_ctrl && !(s_q.ctrl.fast_rc_on && s_q.ctrl.fs) |=> s_q.ctrl.fast_rc_on == $past(pwdata[BIT_FAST_RC_ON]))
		else $error("fast rc on bit did not take the written value");

	chk_fast_follow: assert property (
		opt_fast_sel(s_q.opt) && s_q.ctrl.fast_rc_on |=> fast_rc_enable)
		else $error("fast rc not switched on");

	chk_fast_off: assert property (
		!s_q.ctrl.fast_rc_on && !s_q.use_fast |=> !fast_rc_enable)
		else $error("fast rc not switched off");

	chk_fast_kept: assert property (s_q.use_fast |=> fast_rc_enable)
		else $error("fast rc stopped while it feeds the prescaler");

	chk_src_gate: assert property (!opt_fast_sel(s_q.opt) |-> !s_q.use_fast)
		else $error("fast source selected under wrong option");

	chk_src_boundary: assert property ($changed(s_q.use_fast) |-> $past(cpu_tick))
		else $error("source switched inside a cpu clock period");

	chk_mon_timeout: assert property (seq_osc_lost |=> seq_fallback)
		else $error("monitor missed a stopped oscillator");

	chk_status_sticky: assert property (
		s_q.ev_status && !(wr_status && pwdata[BIT_EV_FAIL]) |=> s_q.ev_status)
		else $error("event status lost without a clear");

	chk_mask_write: assert property (
		wr_mask |=> s_q.ev_mask == $past(pwdata[BIT_EV_FAIL]))
		else $error("mask bit did not take the written value");

	chk_irq_quiet: assert property (
		!(s_q.ev_status && s_q.ev_mask && global_irq_enable) |=> !irq)
		else $error("interrupt raised while masked");

	chk_opt_steady: assert property (s_q.opt_ok |=> $stable(s_q.opt))
		else $error("oscillator option changed after capture");

endmodule

/* src/scsm_pkg.sv */
package scsm_pkg;

	// register indices; the byte address is four times the index
	localparam logic [7:0]  IDX_CLK_CTRL   = 8'hb2;
	localparam logic [7:0]  IDX_IRQ_STATUS = 8'hb3;
	localparam logic [7:0]  IDX_IRQ_MASK   = 8'hb4;
	localparam int          ADDR_W         = 12;
	localparam logic [11:0] ADDR_CLK_CTRL   = {2'h0, IDX_CLK_CTRL, 2'h0};
	localparam logic [11:0] ADDR_IRQ_STATUS = {2'h0, IDX_IRQ_STATUS, 2'h0};
	localparam logic [11:0] ADDR_IRQ_MASK   = {2'h0, IDX_IRQ_MASK, 2'h0};

	// control register field positions, plus the event bit of the status and mask registers
	localparam int BIT_SPEEDUP = 7;
	localparam int BIT_DIV_HI  = 6;
	localparam int BIT_DIV_LO  = 5;
	localparam int BIT_FAIL    = 4;
	localparam int BIT_FAST_RC_ON    = 3;
	localparam int BIT_FS      = 2;
	localparam int BIT_EV_FAIL = 0;

	// reset values
	localparam logic       RST_SPEEDUP = 1'b1;
	localparam logic [1:0] RST_DIV     = 2'h3;
	localparam logic       RST_FAST_RC_ON    = 1'b0;
	localparam logic       RST_FS      = 1'b0;
	localparam logic       RST_MASK    = 1'b0;

	// oscillator type option codes
	localparam logic [3:0] OPT_IRC_A     = 4'h0;
	localparam logic [3:0] OPT_IRC_B     = 4'h3;
	localparam logic [3:0] OPT_X32K      = 4'ha;
	localparam logic [3:0] OPT_X32K_B    = 4'hd;
	localparam logic [3:0] OPT_XHF       = 4'he;
	localparam logic [3:0] OPT_RC128_XHF = 4'h6;

	// divider select codes
	localparam logic [1:0] DIV_1  = 2'h0;
	localparam logic [1:0] DIV_2  = 2'h1;
	localparam logic [1:0] DIV_4  = 2'h2;
	localparam logic [1:0] DIV_12 = 2'h3;

	// timing
	localparam int CLK_PERIOD_PS   = 5000;
	localparam int MON_TIMEOUT_NS  = 100000;
	localparam int MON_TIMEOUT_CYC = (MON_TIMEOUT_NS * 1000) / CLK_PERIOD_PS;
	localparam int MON_CNT_W       = 16;
	localparam logic [2:0] RESUME_TICKS = 3'h4;

	typedef struct packed {
		logic       speedup;
		logic [1:0] div_sel;
		logic       fast_rc_on;
		logic       fs;
	} scsm_ctrl_t;

	typedef enum logic {MON_OK, MON_FAIL} scsm_mon_t;

	// last count value of the prescaler for a select code
	function automatic logic [3:0] div_last(input logic [1:0] sel);
		unique case (sel)
			DIV_1:  div_last = 4'h0;
			DIV_2:  div_last = 4'h1;
			DIV_4:  div_last = 4'h3;
			DIV_12: div_last = 4'hb;
		endcase
	endfunction

	function automatic logic opt_fast_sel(input logic [3:0] opt);
		opt_fast_sel = (opt == OPT_IRC_B) || (opt == OPT_RC128_XHF) || (opt == OPT_X32K);
	endfunction

	function automatic logic opt_xtal32k(input logic [3:0] opt);
		opt_xtal32k = (opt == OPT_X32K) || (opt == OPT_X32K_B);
	endfunction

	function automatic logic opt_monitored(input logic [3:0] opt);
		opt_monitored = opt_xtal32k(opt) || (opt == OPT_XHF);
	endfunction

endpackage

/* src/scsm_prescaler.sv */
`timescale 1ns/1ps
module scsm_prescaler (
	input  wire logic       clk,
	input  wire logic       sys_rst,
	input  wire logic       src_tick,
	input  wire logic [1:0] div_sel,
	output logic            cpu_tick
);
	import scsm_pkg::*;

	typedef struct packed {
		logic [3:0] cnt;
		logic [1:0] sel;
		logic       tick;
	} scsm_div_t;

	scsm_div_t s_q;
	scsm_div_t s_d;

	// a new select is taken only at the end of a whole output period
	always_comb begin
		s_d      = s_q;
		s_d.tick = 1'b0;
		if (src_tick) begin
			if (s_q.cnt == div_last(s_q.sel)) begin
				s_d.cnt  = 4'h0;
				s_d.tick = 1'b1;
				s_d.sel  = div_sel;
			end else begin
				s_d.cnt = 4'(s_q.cnt + 4'h1);
			end
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			s_q <= '{cnt: 4'h0, sel: RST_DIV, tick: 1'b0};
		end else begin
			s_q <= s_d;
		end
	end

	assign cpu_tick = s_q.tick;

	chk_div_wrap_tick: assert property (@(posedge clk) disable iff (sys_rst)
		src_tick && (s_q.cnt == div_last(s_q.sel)) |=> cpu_tick)
		else $error("prescaler did not emit a tick at wrap");

	chk_div_no_early: assert property (@(posedge clk) disable iff (sys_rst)
		(src_tick && (s_q.cnt != div_last(s_q.sel))) || !src_tick |=> !cpu_tick)
		else $error("prescaler emitted a shortened period");

endmodule

/* test/scsm_top_tb.sv */
`timescale 1ns/1ps
module scsm_top_tb;
	import scsm_pkg::*;
	logic        clk = 1'b0;
	logic        sys_rst = 1'b1;
	logic [11:0] paddr = 12'h0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [31:0] pwdata = 32'h0;
	logic [3:0]  pstrb = 4'hf;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [3:0]  osc_type_option = 4'h0;
	logic        osc_tick = 1'b1;
	logic        fast_rc_tick = 1'b0;
	logic        watchdog_rc_tick = 1'b1;
	logic        global_irq_enable = 1'b1;
	logic        cpu_tick;
	logic        fast_rc_enable;
	logic        xtal32k_speedup_en;
	logic        osc_on_watchdog;
	logic        irq;
	int          miscompares = 0;
	int          num_checks = 0;
	logic [31:0] rdat;
	logic        rerr;

	always #2.5 clk = ~clk;

	// short monitor timeout keeps the failure scenario brief
	scsm_top #(.MON_TIMEOUT(50)) dut_u (
		.clk(clk), .sys_rst(sys_rst), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .osc_type_option(osc_type_option), .osc_tick(osc_tick),
		.fast_rc_tick(fast_rc_tick), .watchdog_rc_tick(watchdog_rc_tick),
		.global_irq_enable(global_irq_enable), .cpu_tick(cpu_tick),
		.fast_rc_enable(fast_rc_enable), .xtal32k_speedup_en(xtal32k_speedup_en),
		.osc_on_watchdog(osc_on_watchdog), .irq(irq)
	);

	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask

	// one apb transfer; waits for pready with a bound
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1) begin
			miscompares++;
			tally_and_finish();
		end
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	task automatic rd(input string what, input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(what, exp, rdat);
	endtask

	task automatic rst(input logic [3:0] opt);
		sys_rst <= 1'b1;
		osc_type_option <= opt;
		osc_tick <= 1'b1;
		fast_rc_tick <= 1'b0;
		repeat (10) @(posedge clk);
		sys_rst <= 1'b0;
		repeat (3) @(posedge clk);
	endtask

	// counts cpu ticks over 48 cycles of a steady input tick
	task automatic ticks(input int exp);
		int n;
		n = 0;
		repeat (48) begin
			@(posedge clk);
			if (cpu_tick === 1'b1) n++;
		end
		chk("cpu ticks", exp, n);
	endtask

	task automatic wait_wd(input logic v);
		int n;
		n = 0;
		while (osc_on_watchdog !== v && n < 200) begin
			@(posedge clk);
			n++;
		end
		chk("osc_on_watchdog", {31'h0, v}, {31'h0, osc_on_watchdog});
		if (osc_on_watchdog !== v) begin
			tally_and_finish();
		end
	endtask

	task automatic t_regs;
		rst(OPT_IRC_B);
		rd("ctrl", ADDR_CLK_CTRL, 32'he0);
		rd("mask", ADDR_IRQ_MASK, 32'h0);
		rd("status", ADDR_IRQ_STATUS, 32'h0);
		rd("unmapped", 12'h0, 32'h0);
		chk("slverr", 32'h1, {31'h0, rerr});
		wr(ADDR_CLK_CTRL, 32'hf0);
		rd("ctrl", ADDR_CLK_CTRL, 32'he0);
		pstrb <= 4'he;
		wr(ADDR_CLK_CTRL, 32'h0);
		pstrb <= 4'hf;
		rd("ctrl", ADDR_CLK_CTRL, 32'he0);
	endtask

	task automatic t_divider;
		int nt[4] = '{1, 2, 4, 12};
		rst(OPT_IRC_B);
		for (int i = 0; i < 4; i++) begin
			wr(ADDR_CLK_CTRL, {24'h0, 1'b1, 2'(i), 5'h0});
			repeat (30) @(posedge clk);
			ticks(48 / nt[i]);
		end
		rst(OPT_X32K);
		repeat (30) @(posedge clk);
		ticks(48);
	endtask

	task automatic t_speedup;
		rst(OPT_X32K);
		chk("speedup", 32'h1, {31'h0, xtal32k_speedup_en});
		wr(ADDR_CLK_CTRL, 32'h60);
		repeat (3) @(posedge clk);
		chk("speedup", 32'h0, {31'h0, xtal32k_speedup_en});
		wr(ADDR_CLK_CTRL, 32'he0);
		repeat (3) @(posedge clk);
		chk("speedup", 32'h1, {31'h0, xtal32k_speedup_en});
		rst(OPT_XHF);
		chk("speedup", 32'h0, {31'h0, xtal32k_speedup_en});
	endtask

	task automatic t_fast;
		logic [3:0] op[6] = '{OPT_IRC_B, OPT_RC128_XHF, OPT_X32K, OPT_XHF, OPT_IRC_A, OPT_X32K_B};
		for (int i = 0; i < 6; i++) begin
			rst(op[i]);
			wr(ADDR_CLK_CTRL, 32'h68);
			repeat (3) @(posedge clk);
			chk("fast_rc_enable", {31'h0, (i < 3)}, {31'h0, fast_rc_enable});
		end
		rst(OPT_IRC_B);
		fast_rc_tick <= 1'b1;
		wr(ADDR_CLK_CTRL, 32'h68);
		wr(ADDR_CLK_CTRL, 32'h6c);
		repeat (30) @(posedge clk);
		osc_tick <= 1'b0;
		repeat (30) @(posedge clk);
		ticks(4);
		wr(ADDR_CLK_CTRL, 32'h64);
		rd("ctrl", ADDR_CLK_CTRL, 32'h6c);
		wr(ADDR_CLK_CTRL, 32'h68);
		wr(ADDR_CLK_CTRL, 32'h60);
		// fast rc stays on until the source has switched at a cpu period boundary
		repeat (15) @(posedge clk);
		chk("fast_rc_enable", 32'h0, {31'h0, fast_rc_enable});
		rd("ctrl", ADDR_CLK_CTRL, 32'h60);
	endtask

	task automatic t_monitor;
		rst(OPT_XHF);
		wr(ADDR_IRQ_MASK, 32'h1);
		osc_tick <= 1'b0;
		wait_wd(1'b1);
		rd("ctrl", ADDR_CLK_CTRL, 32'hf0);
		wr(ADDR_CLK_CTRL, 32'he0);
		rd("ctrl", ADDR_CLK_CTRL, 32'hf0);
		chk("irq", 32'h1, {31'h0, irq});
		ticks(4);
		wr(ADDR_IRQ_MASK, 32'h0);
		repeat (3) @(posedge clk);
		chk("irq", 32'h0, {31'h0, irq});
		wr(ADDR_IRQ_MASK, 32'h1);
		global_irq_enable <= 1'b0;
		repeat (3) @(posedge clk);
		chk("irq", 32'h0, {31'h0, irq});
		global_irq_enable <= 1'b1;
		osc_tick <= 1'b1;
		wait_wd(1'b0);
		rd("ctrl", ADDR_CLK_CTRL, 32'he0);
		rd("status", ADDR_IRQ_STATUS, 32'h1);
		wr(ADDR_IRQ_STATUS, 32'h1);
		rd("status", ADDR_IRQ_STATUS, 32'h0);
		repeat (3) @(posedge clk);
		chk("irq", 32'h0, {31'h0, irq});
	endtask

	task automatic t_no_monitor;
		rst(OPT_IRC_B);
		osc_tick <= 1'b0;
		repeat (150) @(posedge clk);
		chk("osc_on_watchdog", 32'h0, {31'h0, osc_on_watchdog});
		rd("status", ADDR_IRQ_STATUS, 32'h0);
	endtask

	initial begin
		t_regs();
		t_divider();
		t_speedup();
		t_fast();
		t_monitor();
		t_no_monitor();
		tally_and_finish();
	end
endmodule
